// File: design/dcms_pkg.sv
// Package: constants and carrier types for the control and monitor block
package dcms_pkg;

    // ==================================================================
    // Command fields
    // ==================================================================
    localparam int DCMS_ADDR_W = 6;        // Address field width
    localparam int DCMS_DATA_W = 14;       // Data field width
    localparam logic [1:0] DCMS_SEL_SFR = 2'h0;  // Special-function select
    localparam logic [5:0] DCMS_CMD_CFG = 6'h0C; // Config write/read
    localparam logic [5:0] DCMS_CMD_MON = 6'h0A; // Monitor select
    localparam logic [5:0] DCMS_CMD_PDN = 6'h08; // Soft power-down
    localparam logic [5:0] DCMS_CMD_PUP = 6'h09; // Soft power-up
    localparam logic [5:0] DCMS_CMD_RST = 6'h0F; // Soft reset

    // ==================================================================
    // Configuration register layout
    // ==================================================================
    localparam int DCMS_POS_PD_MODE = 13;  // Power-down output mode
    localparam int DCMS_POS_REF_LVL = 12;  // Reference level
    localparam int DCMS_POS_BOOST = 11;    // Amplifier boost
    localparam int DCMS_POS_REF_SRC = 10;  // Reference source
    localparam int DCMS_POS_MON_EN = 9;    // Monitor enable
    localparam int DCMS_POS_THERM = 8;     // Thermal guard
    localparam int DCMS_POS_TOG_LO = 2;    // First toggle group bit
    localparam int DCMS_TOG_GROUPS = 5;    // Toggle groups
    localparam int DCMS_GROUP_SIZE = 8;    // Channels per group
    // Stored bits: 13..8 and 6..2; 7,1,0 always zero
    localparam logic [13:0] DCMS_CFG_MASK = 14'h3F7C;
    localparam logic [13:0] DCMS_CFG_RESET = 14'h2000; // Hi-Z pd, rest off

    // ==================================================================
    // Monitor selection
    // ==================================================================
    localparam logic [5:0] DCMS_MON_HIZ = 6'h3F;   // Three-state code
    localparam logic [5:0] DCMS_MON_LAST = 6'h26;  // Highest valid channel
    localparam int DCMS_CHANNELS = 40;

    // Command carrier
    typedef struct packed {
        logic [1:0] register_select;  // {high, low}
        logic read_not_write;          // 1 reads
        logic [5:0] command_address_bits;
        logic [13:0] command_data_word;
    } dcms_cmd_t;

    // Decoded configuration carrier
    typedef struct packed {
        logic powerdown_output_mode_bit;
        logic ref_level_select_bit;
        logic amp_boost_bit;
        logic ref_source_bit;
        logic monitor_enable_bit;
        logic thermal_guard_bit;
        logic [4:0] toggle_group_enables;
    } dcms_cfg_t;

endpackage : dcms_pkg

// File: design/dcms_toggle.sv
// Per-channel toggle select between A and B values on load strobe
module dcms_toggle #(
    parameter int CHANNELS = 40,
    parameter int GROUP_SIZE = 8
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic soft_clear,
    input wire logic load_pulse,
    input wire logic [(CHANNELS+GROUP_SIZE-1)/GROUP_SIZE-1:0] group_en,
    output logic [CHANNELS-1:0] use_b
);
    // ==================================================================
    // One flop per channel
    // ==================================================================
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
            // Flip on each strobe while the group is enabled
            always_ff @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    use_b[ch] <= 1'b0;
                end else if (soft_clear) begin
                    use_b[ch] <= 1'b0;
                end else if (load_pulse && group_en[ch/GROUP_SIZE]) begin
                    use_b[ch] <= ~use_b[ch];
                end else if (!group_en[ch/GROUP_SIZE]) begin
                    // Disabled groups fall back to the A value
                    use_b[ch] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule // dcms_toggle

// File: design/dcms_control.sv
// Command decode, configuration register and monitor selection
// Function
// - Select bits zero means special-function command
// - Code 001100 writes or reads configuration
// - Bit 13 picks power-down output mode
// - Bit 12 picks internal reference level
// - Bit 11 turns amplifier boost on
// - Bit 10 picks internal or external reference
// - Bit 9 enables monitor output for the selected channel
// - Bit 8 enables thermal power-down
// - Soft power-up restarts only when cooled
// - Bits 7, 1, 0 have no effect
// - Bits 6..2 enable toggle per group
// - Load strobe toggles A/B in enabled groups
// - Code 001010 selects monitor channel
// - 0..38 routes, 63 three-states monitor
// - Soft reset restores register defaults
// - Hardware and soft power-down are ORed
module dcms_control #(
    parameter logic REF_LEVEL_DEFAULT = 1'b1, // Variant dependent
    parameter int CHANNELS = 40
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire dcms_pkg::dcms_cmd_t cmd,
    input wire logic output_load_strobe_n,
    input wire logic hw_powerdown,
    input wire logic over_temp,
    output logic read_valid,
    output logic [13:0] read_data,
    output dcms_pkg::dcms_cfg_t cfg,
    output logic powered_down,
    output logic [5:0] monitor_select,
    output logic monitor_output_active,
    output logic monitor_output_hiz,
    output logic [CHANNELS-1:0] toggle_use_b
);
    import dcms_pkg::*;

    // ==================================================================
    // Decoding
    // ==================================================================
    // Shared decode of a special-function code
    function automatic logic is_sfr(input dcms_cmd_t c,
                                    input logic [5:0] code);
        return c.register_select == DCMS_SEL_SFR &&
               c.command_address_bits == code;
    endfunction

    logic [13:0] cfg_reg;        // Stored configuration
    logic soft_pd;               // Soft power-down state
    logic thermal_trip;          // Latched over-temperature shutdown
    logic [1:0] load_sync;       // Strobe synchroniser
    logic [1:0] hw_pd_sync;      // Power-down pin synchroniser
    logic [1:0] temp_sync;       // Temperature flag synchroniser
    logic load_prev;             // Strobe edge history
    logic [5:0] mon_sel;         // Monitor channel

    wire hw_pd = hw_pd_sync[1];
    wire hot = temp_sync[1];
    // Register writes are blocked while powered down
    wire pd_now = soft_pd | hw_pd | thermal_trip;
    wire is_sfr_cmd = cmd_valid && cmd.register_select == DCMS_SEL_SFR;
    wire cfg_wr = cmd_valid && is_sfr(cmd, DCMS_CMD_CFG) &&
                  !cmd.read_not_write && !pd_now;
    wire cfg_rd = cmd_valid && is_sfr(cmd, DCMS_CMD_CFG) &&
                  cmd.read_not_write;
    wire mon_wr = cmd_valid && is_sfr(cmd, DCMS_CMD_MON) &&
                  !cmd.read_not_write && !pd_now;
    wire do_pdn = is_sfr_cmd && is_sfr(cmd, DCMS_CMD_PDN);
    wire do_pup = is_sfr_cmd && is_sfr(cmd, DCMS_CMD_PUP);
    // Soft reset is only honoured when not powered down
    wire do_rst = is_sfr_cmd && is_sfr(cmd, DCMS_CMD_RST) && !pd_now;
    wire load_pulse = !load_sync[1] && load_prev; // Falling edge
    wire [13:0] cfg_default = DCMS_CFG_RESET |
        (14'(REF_LEVEL_DEFAULT) << DCMS_POS_REF_LVL);
    // Unused positions never stored, so they cannot steer anything
    wire [13:0] next_cfg = cmd.command_data_word & DCMS_CFG_MASK;
    wire thermal_on = cfg_reg[DCMS_POS_THERM];

    // ==================================================================
    // Input synchronisers
    // ==================================================================
    // Pins come from outside the clock domain
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            load_sync <= 2'h3;
            hw_pd_sync <= 2'h0;
            temp_sync <= 2'h0;
            load_prev <= 1'b1;
        end else begin
            load_sync <= {load_sync[0], output_load_strobe_n};
            hw_pd_sync <= {hw_pd_sync[0], hw_powerdown};
            temp_sync <= {temp_sync[0], over_temp};
            load_prev <= load_sync[1];
        end
    end

    // ==================================================================
    // Configuration register
    // ==================================================================
    // Written by its command, restored by soft reset
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cfg_reg <= DCMS_CFG_RESET;
        end else if (do_rst) begin
            cfg_reg <= cfg_default;
        end else if (cfg_wr) begin
            cfg_reg <= next_cfg;
        end
    end

    // Variant reference level drives the decoded output for one cycle after reset release, then bit 12 does
    logic strap_done; // Default level taken
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            strap_done <= 1'b0;
        end else begin
            strap_done <= 1'b1;
        end
    end

    // ==================================================================
    // Power-down state
    // ==================================================================
    // Thermal trip sticks until a soft power-up finds the die cool
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            soft_pd <= 1'b0;
            thermal_trip <= 1'b0;
        end else begin
            if (do_pdn) begin
                soft_pd <= 1'b1;
            end else if (do_pup) begin
                soft_pd <= 1'b0;
            end
            if (thermal_on && hot) begin
                thermal_trip <= 1'b1;
            end else if (do_pup && !hot) begin
                thermal_trip <= 1'b0;
            end
        end
    end

    // ==================================================================
    // Monitor selection
    // ==================================================================
    // Held until the next monitor command or soft reset; taken whether or not the monitor is enabled
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mon_sel <= DCMS_MON_HIZ;
        end else if (do_rst) begin
            mon_sel <= DCMS_MON_HIZ;
        end else if (mon_wr) begin
            mon_sel <= cmd.command_data_word[13:8];
        end
    end

    // ==================================================================
    // Outputs
    // ==================================================================
    // All outputs registered
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            read_valid <= 1'b0;
            read_data <= 14'h0000;
            cfg <= '0;
            powered_down <= 1'b0;
            monitor_select <= DCMS_MON_HIZ;
            monitor_output_active <= 1'b0;
            monitor_output_hiz <= 1'b1;
        end else begin
            read_valid <= cfg_rd;
            if (cfg_rd) begin
                read_data <= cfg_reg & DCMS_CFG_MASK;
            end
            cfg.powerdown_output_mode_bit <= cfg_reg[DCMS_POS_PD_MODE];
            cfg.ref_level_select_bit <= strap_done ?
                cfg_reg[DCMS_POS_REF_LVL] : REF_LEVEL_DEFAULT;
            cfg.amp_boost_bit <= cfg_reg[DCMS_POS_BOOST];
            cfg.ref_source_bit <= cfg_reg[DCMS_POS_REF_SRC];
            cfg.monitor_enable_bit <= cfg_reg[DCMS_POS_MON_EN];
            cfg.thermal_guard_bit <= thermal_on;
            cfg.toggle_group_enables <=
                cfg_reg[DCMS_POS_TOG_LO +: DCMS_TOG_GROUPS];
            powered_down <= pd_now;
            monitor_select <= mon_sel;
            // Monitor drives only when enabled and a valid channel chosen
            monitor_output_active <= cfg_reg[DCMS_POS_MON_EN] &&
                mon_sel <= DCMS_MON_LAST;
            monitor_output_hiz <= !cfg_reg[DCMS_POS_MON_EN] ||
                mon_sel == DCMS_MON_HIZ;
        end
    end

    // ==================================================================
    // Toggle channels
    // ==================================================================
    dcms_toggle #(
        .CHANNELS(CHANNELS),
        .GROUP_SIZE(DCMS_GROUP_SIZE)
    ) u_toggle (
        .ref_clk(ref_clk),
        .reset(reset),
        .soft_clear(do_rst),
        .load_pulse(load_pulse),
        .group_en(cfg_reg[DCMS_POS_TOG_LO +: DCMS_TOG_GROUPS]),
        .use_b(toggle_use_b)
    );

    // ==================================================================
    // Checks
    // ==================================================================
    sequence s_cfg_write;
        cfg_wr;
    endsequence

    AST_CFG_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
        s_cfg_write ##2 1'b1 |-> cfg.amp_boost_bit == $past(next_cfg[11], 2))
        else $error("boost bit not taken from write");
    AST_READ_ONE: assert property (@(posedge ref_clk) disable iff (reset)
        cfg_rd |=> read_valid && read_data == $past(cfg_reg & DCMS_CFG_MASK))
        else $error("read answer wrong");
    AST_UNUSED: assert property (@(posedge ref_clk) disable iff (reset)
        cfg_reg[7] == 1'b0 && cfg_reg[1:0] == 2'h0)
        else $error("unused bits stored");
    AST_MON_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
        !mon_wr && !do_rst |=> $stable(mon_sel))
        else $error("monitor select changed");
    AST_MON_WR: assert property (@(posedge ref_clk) disable iff (reset)
        mon_wr && !do_rst |=> mon_sel == $past(cmd.command_data_word[13:8]))
        else $error("monitor select not taken");
    AST_HIZ: assert property (@(posedge ref_clk) disable iff (reset)
        mon_sel == DCMS_MON_HIZ |=> monitor_output_hiz && !monitor_output_active)
        else $error("monitor not three-stated");
    AST_THERM: assert property (@(posedge ref_clk) disable iff (reset)
        thermal_on && hot |=> ##1 powered_down)
        else $error("thermal trip missed");
    AST_PUP_HOT: assert property (@(posedge ref_clk) disable iff (reset)
        thermal_trip && hot && !do_rst |=> thermal_trip)
        else $error("restart while hot");
    AST_PD_OR: assert property (@(posedge ref_clk) disable iff (reset)
        hw_pd |=> powered_down)
        else $error("hardware power-down ignored");
    AST_SOFT_RST: assert property (@(posedge ref_clk) disable iff (reset)
        do_rst |=> cfg_reg == $past(cfg_default))
        else $error("soft reset not default");
endmodule // dcms_control

// File: testbench/dcms_host.sv
// Host model issuing special-function commands to the control block
module dcms_host (
    input wire logic ref_clk,
    input wire logic read_valid,
    input wire logic [13:0] read_data,
    output logic cmd_valid,
    output dcms_pkg::dcms_cmd_t cmd
);
    import dcms_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idle, command lines parked at a neutral value
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end

    // ==================================================================
    // Command issue
    // ==================================================================
    // One command held across exactly one taking edge
    task automatic send(input logic [1:0] sel, input logic rnw,
                        input logic [5:0] addr, input logic [13:0] data);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd <= {sel, rnw, addr, data};
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        // Inverted leftovers, so stale fields are never mistaken for live
        cmd <= ~{sel, rnw, addr, data};
    endtask

    // Configuration write, all fourteen data bits
    task automatic wr_cfg(input logic [13:0] data);
        send(DCMS_SEL_SFR, 1'b0, DCMS_CMD_CFG, data);
    endtask

    // Monitor select, low byte filled with noise that must be ignored
    task automatic mon(input logic [5:0] code);
        send(DCMS_SEL_SFR, 1'b0, DCMS_CMD_MON, {code, 8'hA5});
    endtask

    // Configuration read, bounded wait for the answer pulse
    task automatic read_cfg(output logic [13:0] value);
        int n;
        send(DCMS_SEL_SFR, 1'b1, DCMS_CMD_CFG, 14'h0000);
        n = 0;
        while (read_valid !== 1'b1 && n < 4) begin
            @(negedge ref_clk);
            n++;
        end
        value = (read_valid === 1'b1) ? read_data : 14'hXXXX;
    endtask
endmodule // dcms_host

// File: testbench/test_dac_control_and_monitor_select.sv
// Self-checking bench for the control register and monitor select block
module test_dac_control_and_monitor_select;
    import dcms_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ==================================================================
    // Signals
    // ==================================================================
    localparam logic REF_DEF = 1'b1; // Variant default reference level
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic strobe_n = 1'b1; // Load strobe, active low
    logic hw_pd = 1'b0;
    logic over_temp = 1'b0;
    logic cmd_valid;
    dcms_cmd_t cmd;
    logic read_valid;
    logic [13:0] read_data;
    dcms_cfg_t cfg;
    logic powered_down;
    logic [5:0] mon_sel;
    logic mon_act;
    logic mon_hiz;
    logic [39:0] use_b;
    int bad_count = 0;
    int compares = 0;

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    dcms_control #(.REF_LEVEL_DEFAULT(REF_DEF), .CHANNELS(40)) dcms_control_i (
        .ref_clk(ref_clk), .reset(reset), .cmd_valid(cmd_valid),
        .cmd(cmd), .output_load_strobe_n(strobe_n),
        .hw_powerdown(hw_pd), .over_temp(over_temp),
        .read_valid(read_valid), .read_data(read_data), .cfg(cfg),
        .powered_down(powered_down), .monitor_select(mon_sel),
        .monitor_output_active(mon_act), .monitor_output_hiz(mon_hiz),
        .toggle_use_b(use_b));

    dcms_host dcms_host_i (
        .ref_clk(ref_clk), .read_valid(read_valid),
        .read_data(read_data), .cmd_valid(cmd_valid), .cmd(cmd));

    // ==================================================================
    // Helpers
    // ==================================================================
    // Compare and count; four-state match so unknowns fail
    task automatic check(input string name, input logic [39:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Wait whole cycles, sampling mid-period
    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic end_of_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ==================================================================
    // Scenarios
    // ==================================================================
    // Defaults after hardware reset
    task automatic t_reset();
        logic [13:0] v;
        check("monitor code", mon_sel, 40'h3F);
        check("monitor hiz", mon_hiz, 40'h1);
        dcms_host_i.read_cfg(v);
        check("reset config", v, 40'h2000);
    endtask

    // Write, decoded fields, then readback with dead bits cleared
    task automatic t_write(input logic [13:0] d, rd, input logic [10:0] f);
        logic [13:0] v;
        dcms_host_i.wr_cfg(d);
        settle(3);
        check("decoded config", cfg, f);
        dcms_host_i.read_cfg(v);
        check("config readback", v, rd);
    endtask

    // Non-special register selects must leave the register alone
    task automatic t_select();
        logic [13:0] v;
        dcms_host_i.send(2'h3, 1'b0, DCMS_CMD_CFG, 14'h0000);
        dcms_host_i.send(2'h1, 1'b0, DCMS_CMD_CFG, 14'h0000);
        dcms_host_i.read_cfg(v);
        check("select ignored", v, 40'h2A00);
    endtask

    // Route lowest and highest channel, then three-state
    task automatic t_monitor();
        logic [5:0] codes [3] = '{6'h00, 6'h26, 6'h3F};
        dcms_host_i.wr_cfg(14'h2200);
        for (int i = 0; i < 3; i++) begin
            dcms_host_i.mon(codes[i]);
            settle(3);
            check("monitor code", mon_sel, codes[i]);
            check("monitor routed", mon_act, codes[i] != 6'h3F);
            check("monitor hiz", mon_hiz, codes[i] == 6'h3F);
        end
        // Monitor disabled keeps the pin off the monitor path
        dcms_host_i.wr_cfg(14'h2000);
        dcms_host_i.mon(6'h05);
        settle(3);
        check("monitor disabled", {mon_act, mon_hiz}, 40'h1);
    endtask

    // Groups 0, 2, 4 enabled; two strobes go to B and back to A
    task automatic t_toggle();
        dcms_host_i.wr_cfg(14'h2054);
        settle(3);
        for (int i = 0; i < 2; i++) begin
            @(posedge ref_clk);
            strobe_n <= 1'b0;
            repeat (2) @(posedge ref_clk);
            strobe_n <= 1'b1;
            settle(5);
            check("toggle select", use_b,
                  (i == 0) ? 40'hFF00FF00FF : 40'h0);
        end
    endtask

    // Pin and soft power-down, writes refused during pin power-down
    task automatic t_powerdown();
        logic [13:0] v;
        @(posedge ref_clk);
        hw_pd <= 1'b1;
        settle(5);
        check("pin power-down", powered_down, 40'h1);
        dcms_host_i.wr_cfg(14'h3FFF);
        @(posedge ref_clk);
        hw_pd <= 1'b0;
        settle(5);
        check("pin release", powered_down, 40'h0);
        dcms_host_i.read_cfg(v);
        check("write refused", v, 40'h2054);
        dcms_host_i.send(DCMS_SEL_SFR, 1'b0, DCMS_CMD_PDN, 14'h0000);
        settle(3);
        check("soft power-down", powered_down, 40'h1);
        dcms_host_i.send(DCMS_SEL_SFR, 1'b0, DCMS_CMD_PUP, 14'h0000);
        settle(3);
        check("soft power-up", powered_down, 40'h0);
    endtask

    // Hot die ignored until guard on; restart only once cooled
    task automatic t_thermal();
        @(posedge ref_clk);
        over_temp <= 1'b1;
        settle(5);
        check("guard off", powered_down, 40'h0);
        dcms_host_i.wr_cfg(14'h2100);
        settle(6);
        check("thermal trip", powered_down, 40'h1);
        dcms_host_i.send(DCMS_SEL_SFR, 1'b0, DCMS_CMD_PUP, 14'h0000);
        settle(5);
        check("hot power-up", powered_down, 40'h1);
        @(posedge ref_clk);
        over_temp <= 1'b0;
        settle(5);
        dcms_host_i.send(DCMS_SEL_SFR, 1'b0, DCMS_CMD_PUP, 14'h0000);
        settle(5);
        check("cool power-up", powered_down, 40'h0);
    endtask

    // Soft reset restores defaults and three-states the monitor
    task automatic t_soft_reset();
        logic [13:0] v;
        dcms_host_i.mon(6'h05);
        dcms_host_i.send(DCMS_SEL_SFR, 1'b0, DCMS_CMD_RST, 14'h0000);
        settle(4);
        check("monitor after reset", mon_sel, 40'h3F);
        dcms_host_i.read_cfg(v);
        check("soft reset config", v, {1'b1, REF_DEF, 12'h000});
    endtask

    // ==================================================================
    // Main sequence and watchdog
    // ==================================================================
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_write(14'h3FFF, 14'h3F7C, 11'h7FF);
        t_write(14'h2A83, 14'h2A00, 11'h540);
        t_select();
        t_monitor();
        t_toggle();
        t_powerdown();
        t_thermal();
        t_soft_reset();
        end_of_test();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge ref_clk);
        bad_count++;
        end_of_test();
    end
endmodule // test_dac_control_and_monitor_select
